// file: inc/dcp_pkg.sv
// Purpose: Shared constants and carrier types of the drive process image block.
// Assumes: One 10 MHz clock; registers reached over AHB-Lite with 32-bit words.
// Notes: Word indices map to byte addresses as four times the index.
package dcp_pkg;

    // Clock and image geometry
    localparam int CLK_PERIOD_NS = 100;
    localparam int IMG_BYTES = 6;
    localparam int IMG_WORDS = 3;
    localparam int POS_BYTES = 4;

    // Register word indices; byte address is four times the index
    localparam logic [2:0] IDX_DRIVE_WORD = 3'h0;
    localparam logic [2:0] IDX_POS_LOW = 3'h1;
    localparam logic [2:0] IDX_POS_HIGH = 3'h2;
    localparam logic [2:0] IDX_CTRL_READBACK = 3'h4;
    localparam logic [2:0] IDX_SET_LOW_READBACK = 3'h5;
    localparam logic [2:0] IDX_SET_HIGH_READBACK = 3'h6;

    // Field positions
    localparam int EXT_SELECT_BIT = 3;
    localparam int EXT_SELECT_ACK_BIT = 3;

    // Values after reset
    localparam logic [15:0] CTRL_RESET = 16'h0000;
    localparam logic [15:0] SETPOINT_RESET = 16'h0000;
    localparam logic [31:0] RDATA_RESET = 32'h0000_0000;

    // Time to settle the input image after a content switch
    localparam int SWITCH_SETTLE_NS = 500;
    localparam int SWITCH_SETTLE_CYCLES =
        (SWITCH_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // AHB-Lite encodings
    localparam logic [1:0] HTRANS_IDLE = 2'h0;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] HSIZE_WORD = 3'h2;
    localparam logic HRESP_OKAY = 1'h0;

    // Output image as the drive sees it
    typedef struct packed {
        logic [7:0] driveControlByteOne;
        logic [7:0] driveControlByteZero;
        logic [31:0] setpointPosition;
    } dcp_out_image_t;

    // Drive-side values feeding the input image
    typedef struct packed {
        logic [7:0] driveStatusByteOne;
        logic [7:0] driveStatusByteZero;
        logic [31:0] actualPosition;
        logic [31:0] extendedStatus;
    } dcp_drive_in_t;

    // Captured address phase of a bus transfer
    typedef struct packed {
        logic write;
        logic [2:0] index;
    } dcp_bus_req_t;

    // Content switch sequencer states, one-hot
    typedef enum logic [1:0] {
        SEL_STEADY = 2'b01,
        SEL_SETTLE = 2'b10
    } dcp_sel_state_t;

endpackage

// file: hdl/dcp_image_select.sv
// Purpose: Chooses position or extended status for input words one and two.
// Assumes: Request bit and drive data come from logic on the same clock.
// Notes: Acknowledge and new content change on the same clock edge.
`timescale 1ns/1ps
module dcp_image_select #(
    parameter int SETTLE_CYCLES = dcp_pkg::SWITCH_SETTLE_CYCLES
)(
    input wire logic sys_clk, // System clock
    input wire logic sys_rst, // Asynchronous reset, active high
    input wire logic extSelectReq, // Requested content, 1 = extended status
    input wire logic [31:0] actualPosition, // Live actual position
    input wire logic [31:0] extendedStatus, // Extended status bytes five..two
    output logic extSelectAck, // Content now shown
    output logic [15:0] inWordOne, // Input word one
    output logic [15:0] inWordTwo // Input word two
);

    dcp_pkg::dcp_sel_state_t state_q, state_d;
    logic [7:0] settle_q, settle_d;
    logic shown_q, shown_d;
    logic [15:0] wordOne_q, wordOne_d;
    logic [15:0] wordTwo_q, wordTwo_d;

    // Switch sequencing; a new request waits out the settle time first
    always_comb
    begin
        state_d = state_q;
        settle_d = settle_q;
        shown_d = shown_q;
        case (state_q)
            dcp_pkg::SEL_STEADY:
            begin
                if (extSelectReq != shown_q)
                begin
                    state_d = dcp_pkg::SEL_SETTLE;
                    settle_d = 8'(SETTLE_CYCLES - 1);
                end
            end
            dcp_pkg::SEL_SETTLE:
            begin
                if (settle_q == 8'h00)
                begin
                    shown_d = extSelectReq;
                    state_d = dcp_pkg::SEL_STEADY;
                end
                else
                begin
                    settle_d = settle_q - 8'h01;
                end
            end
            default:
            begin
                state_d = dcp_pkg::SEL_STEADY;
            end
        endcase
        // Mux from the next selection so data and acknowledge never disagree
        if (shown_d)
        begin
            wordOne_d = extendedStatus[15:0];
            wordTwo_d = extendedStatus[31:16];
        end
        else
        begin
            wordOne_d = actualPosition[15:0];
            wordTwo_d = actualPosition[31:16];
        end
    end

    // State registers
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            state_q <= dcp_pkg::SEL_STEADY;
            settle_q <= 8'h00;
            shown_q <= 1'b0;
            wordOne_q <= 16'h0000;
            wordTwo_q <= 16'h0000;
        end
        else
        begin
            state_q <= state_d;
            settle_q <= settle_d;
            shown_q <= shown_d;
            wordOne_q <= wordOne_d;
            wordTwo_q <= wordTwo_d;
        end
    end

    assign extSelectAck = shown_q;
    assign inWordOne = wordOne_q;
    assign inWordTwo = wordTwo_q;

endmodule

// file: hdl/dcp_process_image.sv
// Purpose: AHB-Lite register bank holding a drive's six-byte process images.
// Assumes: Drive-side inputs are on sys_clk; single word transfers only.
// Notes: A write reaches the output image, a read returns the input image or a readback of the output words.
`timescale 1ns/1ps
module dcp_process_image #(
    parameter int SETTLE_CYCLES = dcp_pkg::SWITCH_SETTLE_CYCLES
)(
    input wire logic sys_clk, // System clock, 10 MHz
    input wire logic sys_rst, // Asynchronous reset, active high
    input wire logic hsel, // Slave select
    input wire logic [31:0] haddr, // Byte address
    input wire logic [1:0] htrans, // Transfer type
    input wire logic hwrite, // Write when high
    input wire logic [2:0] hsize, // Transfer size
    input wire logic [31:0] hwdata, // Write data
    input wire logic hready, // Bus ready
    output logic hreadyout, // Slave ready
    output logic [31:0] hrdata, // Read data
    output logic hresp, // Response, always OKAY
    input wire dcp_pkg::dcp_drive_in_t driveIn, // Drive status and position
    output dcp_pkg::dcp_out_image_t outImage, // Control bytes and setpoint
    output logic outImageStrobe // Pulse when the output image changes
);

    // Word index of an address
    function automatic logic [2:0] wordIndex(input logic [31:0] addr);
        return addr[4:2];
    endfunction

    // Whether an address hits the register window at all
    function automatic logic inWindow(input logic [31:0] addr);
        return (addr[31:5] == 27'h0000000) && (addr[1:0] == 2'h0);
    endfunction

    // Transfer acceptance and captured address phase
    logic accept;
    dcp_pkg::dcp_bus_req_t req_q, req_d;
    logic wrPend_q, wrPend_d;

    // Output image state
    logic [15:0] ctrlWord_q, ctrlWord_d;
    logic [15:0] setLowStage_q, setLowStage_d;
    logic [15:0] setLow_q, setLow_d;
    logic [15:0] setHigh_q, setHigh_d;
    logic strobe_q, strobe_d;

    // Bus answer state
    logic [31:0] rdata_q, rdata_d;
    logic readyOut_q;
    logic resp_q;

    // Input image pieces
    logic extAck;
    logic [15:0] inWordOne;
    logic [15:0] inWordTwo;
    logic [15:0] statusWord;

    // Only whole-word transfers inside the window are acted upon
    assign accept = hsel && htrans[1] && hready && (hsize == dcp_pkg::HSIZE_WORD)
        && inWindow(haddr);

    // Content switch and acknowledge for input words one and two
    dcp_image_select #(
        .SETTLE_CYCLES(SETTLE_CYCLES)
    ) u_select (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .extSelectReq(ctrlWord_q[8 + dcp_pkg::EXT_SELECT_BIT]),
        .actualPosition(driveIn.actualPosition),
        .extendedStatus(driveIn.extendedStatus),
        .extSelectAck(extAck),
        .inWordOne(inWordOne),
        .inWordTwo(inWordTwo)
    );

    // Status word: drive bytes pass through, acknowledge bit is ours
    always_comb
    begin
        statusWord = {driveIn.driveStatusByteOne, driveIn.driveStatusByteZero};
        statusWord[8 + dcp_pkg::EXT_SELECT_ACK_BIT] = extAck;
    end

    // Address phase capture; the data phase of a write follows one edge later
    always_comb
    begin
        req_d = req_q;
        wrPend_d = 1'b0;
        if (accept)
        begin
            req_d.write = hwrite;
            req_d.index = wordIndex(haddr);
            wrPend_d = hwrite;
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            req_q <= '0;
            wrPend_q <= 1'b0;
        end
        else
        begin
            req_q <= req_d;
            wrPend_q <= wrPend_d;
        end
    end

    // Output image writes; the setpoint low word is staged so the drive
    // never sees a half-updated 32-bit position
    always_comb
    begin
        ctrlWord_d = ctrlWord_q;
        setLowStage_d = setLowStage_q;
        setLow_d = setLow_q;
        setHigh_d = setHigh_q;
        strobe_d = 1'b0;
        if (wrPend_q)
        begin
            case (req_q.index)
                dcp_pkg::IDX_DRIVE_WORD:
                begin
                    ctrlWord_d = hwdata[15:0];
                    strobe_d = 1'b1;
                end
                dcp_pkg::IDX_POS_LOW:
                begin
                    setLowStage_d = hwdata[15:0];
                end
                dcp_pkg::IDX_POS_HIGH:
                begin
                    setLow_d = setLowStage_q;
                    setHigh_d = hwdata[15:0];
                    strobe_d = 1'b1;
                end
                default:
                begin
                    strobe_d = 1'b0; // Read-only or unused words ignore writes
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            ctrlWord_q <= dcp_pkg::CTRL_RESET;
            setLowStage_q <= dcp_pkg::SETPOINT_RESET;
            setLow_q <= dcp_pkg::SETPOINT_RESET;
            setHigh_q <= dcp_pkg::SETPOINT_RESET;
            strobe_q <= 1'b0;
        end
        else
        begin
            ctrlWord_q <= ctrlWord_d;
            setLowStage_q <= setLowStage_d;
            setLow_q <= setLow_d;
            setHigh_q <= setHigh_d;
            strobe_q <= strobe_d;
        end
    end

    // Read data is prepared at the address phase so no wait state is needed;
    // readback words show the value before a write that ends on the same edge
    always_comb
    begin
        rdata_d = rdata_q;
        if (accept && !hwrite)
        begin
            case (wordIndex(haddr))
                dcp_pkg::IDX_DRIVE_WORD:
                begin
                    rdata_d = {16'h0000, statusWord};
                end
                dcp_pkg::IDX_POS_LOW:
                begin
                    rdata_d = {16'h0000, inWordOne};
                end
                dcp_pkg::IDX_POS_HIGH:
                begin
                    rdata_d = {16'h0000, inWordTwo};
                end
                dcp_pkg::IDX_CTRL_READBACK:
                begin
                    rdata_d = {16'h0000, ctrlWord_q};
                end
                dcp_pkg::IDX_SET_LOW_READBACK:
                begin
                    rdata_d = {16'h0000, setLowStage_q};
                end
                dcp_pkg::IDX_SET_HIGH_READBACK:
                begin
                    rdata_d = {16'h0000, setHigh_q};
                end
                default:
                begin
                    rdata_d = 32'h0000_0000;
                end
            endcase
        end
        else if (hsel && htrans[1] && hready && !hwrite)
        begin
            rdata_d = 32'h0000_0000; // Unmapped or sub-word read answers zero
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            rdata_q <= dcp_pkg::RDATA_RESET;
            readyOut_q <= 1'b1;
            resp_q <= dcp_pkg::HRESP_OKAY;
        end
        else
        begin
            rdata_q <= rdata_d;
            readyOut_q <= 1'b1;
            resp_q <= dcp_pkg::HRESP_OKAY;
        end
    end

    // Outputs straight from flip-flops
    assign hrdata = rdata_q;
    assign hreadyout = readyOut_q;
    assign hresp = resp_q;
    assign outImage.driveControlByteOne = ctrlWord_q[15:8];
    assign outImage.driveControlByteZero = ctrlWord_q[7:0];
    assign outImage.setpointPosition = {setHigh_q, setLow_q};
    assign outImageStrobe = strobe_q;

endmodule

// file: verification/dcp_process_image_sva.sv
// Purpose: Bus and image timing checks for the drive process image bank.
// Assumes: Zero wait state slave, whole word transfers, one clock.
// Notes: Selection checks wait until the request bit has been quiet long enough.
`timescale 1ns/1ps
module dcp_process_image_sva #(
    parameter int SETTLE_CYCLES = 5
)(
    input wire logic sys_clk, // Clock
    input wire logic sys_rst, // Reset, active high
    input wire logic hsel, // Select
    input wire logic [31:0] haddr, // Address
    input wire logic [1:0] htrans, // Transfer type
    input wire logic hwrite, // Write
    input wire logic [2:0] hsize, // Size
    input wire logic [31:0] hwdata, // Write data
    input wire logic hready, // Bus ready
    input wire logic hreadyout, // Slave ready
    input wire logic [31:0] hrdata, // Read data
    input wire logic hresp, // Response
    input wire dcp_pkg::dcp_drive_in_t driveIn, // Drive values
    input wire dcp_pkg::dcp_out_image_t outImage, // Output image
    input wire logic outImageStrobe // Output image pulse
);
    logic [4:0] phase_q;
    logic [4:0] phase_d;
    logic reqPrev_q;
    logic [9:0] quiet_q;
    logic [9:0] quiet_d;
    // Data phase as {taken, write, index}; quiet counts cycles since the request moved
    always_comb
    begin
        phase_d = {hsel && htrans[1] && hready && hsize == 3'h2 && haddr[31:5] == 27'h0
            && haddr[1:0] == 2'h0, hwrite, haddr[4:2]};
        quiet_d = quiet_q + {9'h0, quiet_q != 10'h3ff};
        if (outImage.driveControlByteOne[3] != reqPrev_q)
            quiet_d = 10'h0;
    end
    // Saturating counter keeps long idle spans from wrapping into a false window
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            phase_q <= 5'h00;
            reqPrev_q <= 1'b0;
            quiet_q <= 10'h000;
        end
        else
        begin
            phase_q <= phase_d;
            reqPrev_q <= outImage.driveControlByteOne[3];
            quiet_q <= quiet_d;
        end
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    chk_ready_okay: assert property (hreadyout && !hresp)
        else $error("slave not ready or not okay");
    chk_read_upper: assert property (phase_q[4:3] == 2'b10 |-> hrdata[31:16] == 16'h0)
        else $error("read data upper half not zero");
    chk_ctrl_write: assert property (phase_q == 5'h18 |=> outImageStrobe
        && outImage[47:32] == $past(hwdata[15:0]))
        else $error("control word write not in output image");
    chk_low_hidden: assert property (phase_q == 5'h19 |=> $stable(outImage.setpointPosition))
        else $error("staged setpoint low leaked to output image");
    chk_setpoint_commit: assert property (phase_q == 5'h1a |=> outImageStrobe
        && outImage[31:16] == $past(hwdata[15:0]))
        else $error("setpoint high write not committed");
    chk_status_pass: assert property (phase_q == 5'h10 |-> (hrdata[15:0] & 16'hf7ff) ==
        ({$past(driveIn.driveStatusByteOne), $past(driveIn.driveStatusByteZero)} & 16'hf7ff))
        else $error("status word differs from drive status");
    chk_ack_settled: assert property (phase_q == 5'h10 && int'(quiet_q) > SETTLE_CYCLES + 1
        |-> hrdata[11] == outImage.driveControlByteOne[3])
        else $error("acknowledge does not follow request");
    // Words one and two are registered first, so read data lags the drive by two edges
    chk_word_one: assert property (phase_q == 5'h11 && int'(quiet_q) > SETTLE_CYCLES + 1
        |-> hrdata[15:0] == (outImage.driveControlByteOne[3] ?
        $past(driveIn.extendedStatus[15:0], 2) : $past(driveIn.actualPosition[15:0], 2)))
        else $error("input word one wrong content");
    chk_word_two: assert property (phase_q == 5'h12 && int'(quiet_q) > SETTLE_CYCLES + 1
        |-> hrdata[15:0] == (outImage.driveControlByteOne[3] ?
        $past(driveIn.extendedStatus[31:16], 2) : $past(driveIn.actualPosition[31:16], 2)))
        else $error("input word two wrong content");
endmodule
bind dcp_process_image dcp_process_image_sva #(.SETTLE_CYCLES(SETTLE_CYCLES)) i_sva (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .driveIn(driveIn),
    .outImage(outImage), .outImageStrobe(outImageStrobe));

// file: verification/dcp_drive_model.sv
// Purpose: Behavioural drive that answers the output image with status and position.
// Assumes: The drive reacts within the same cycle as the output image changes.
// Notes: Status byte one bit three is inverted so the acknowledge override shows.
`timescale 1ns/1ps
module dcp_drive_model (
    input wire dcp_pkg::dcp_out_image_t outImage, // Commands from the bank
    output dcp_pkg::dcp_drive_in_t driveIn // Status and position to the bank
);
    // Every returned byte depends on a written value, so stuck paths show up
    always_comb
    begin
        driveIn.driveStatusByteOne = outImage.driveControlByteOne ^ 8'h5a;
        driveIn.driveStatusByteZero = ~outImage.driveControlByteZero;
        driveIn.actualPosition = outImage.setpointPosition + 32'h1;
        driveIn.extendedStatus = {outImage.setpointPosition[15:0], outImage[47:32]}
            ^ 32'h3c3c_c3c3;
    end
endmodule

// file: verification/dcp_process_image_tb_top.sv
// Purpose: Self-checking bench for the drive process image bank.
// Assumes: Zero wait state slave; drive model answers combinationally.
// Notes: Settle count shortened to keep content switches brief.
`timescale 1ns/1ps
module dcp_process_image_tb_top;
    localparam int ST = 3;
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic hreadyout;
    logic [31:0] hrdata;
    logic hresp;
    dcp_pkg::dcp_drive_in_t driveIn;
    dcp_pkg::dcp_out_image_t outImage;
    logic outImageStrobe;
    int fails = 0;
    int tests_run = 0;
    logic [15:0] ctl = 16'h0;
    logic [15:0] lo;
    logic [31:0] sp = 32'h0;
    logic [31:0] rd;
    logic ext;
    always #50 sys_clk = ~sys_clk;
    dcp_process_image #(.SETTLE_CYCLES(ST)) i_dcp_process_image (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .driveIn(driveIn),
        .outImage(outImage), .outImageStrobe(outImageStrobe));
    dcp_drive_model i_dcp_drive_model (.outImage(outImage), .driveIn(driveIn));
    // Compare and count
    task automatic check(input string what, input logic [47:0] seen, input logic [47:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            fails++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // One single transfer; each phase is held until hready is seen high
    task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
        input logic [2:0] sz);
        hsel <= 1'b1;
        htrans <= dcp_pkg::HTRANS_NONSEQ;
        haddr <= a;
        hwrite <= w;
        hsize <= sz;
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= dcp_pkg::HTRANS_IDLE;
        hwdata <= d;
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task automatic wr(input logic [31:0] a, input logic [15:0] d);
        xfer(1'b1, a, {16'($urandom()), d}, dcp_pkg::HSIZE_WORD);
    endtask
    task automatic rdchk(input string what, input logic [31:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0, dcp_pkg::HSIZE_WORD);
        check(what, rd, exp);
        check("hresp", hresp, 48'(dcp_pkg::HRESP_OKAY));
    endtask
    // Sample the output image mid-cycle, after the write edge has landed
    task automatic lookOut(input logic pulse);
        @(negedge sys_clk);
        check("outImage", outImage, {ctl, sp});
        check("outImageStrobe", outImageStrobe, pulse);
        @(posedge sys_clk);
    endtask
    function automatic logic [31:0] expStat(input logic ack);
        logic [31:0] r;
        r = {16'h0, ctl[15:8] ^ 8'h5a, ~ctl[7:0]};
        r[11] = ack;
        return r;
    endfunction
    function automatic logic [31:0] expWord(input logic e, input logic hi);
        logic [31:0] v;
        v = e ? {sp[15:0], ctl} ^ 32'h3c3c_c3c3 : sp + 32'h1;
        return {16'h0, hi ? v[31:16] : v[15:0]};
    endfunction
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // Watchdog: far beyond the fewer than two hundred cycles the tests need
    initial
    begin
        repeat (5000) @(posedge sys_clk);
        fails++;
        finish_test();
    end
    initial
    begin
        void'($urandom(32'h9347));
        repeat (2) @(posedge sys_clk);
        sys_rst <= 1'b0;
        @(posedge sys_clk);
        rdchk("ctrl readback", 32'h10, {16'h0, dcp_pkg::CTRL_RESET});
        rdchk("setpoint high", 32'h18, {16'h0, dcp_pkg::SETPOINT_RESET});
        rdchk("word one", 32'h4, expWord(1'b0, 1'b0));
        lookOut(1'b0);
        $display("test reset done");
        // Position mode with random and extreme control and setpoint values
        for (int i = 0; i < 6; i++)
        begin
            ctl = (i == 0) ? 16'hf7ff : (i == 1) ? 16'h0 : 16'($urandom()) & 16'hf7ff;
            wr(32'h0, ctl);
            lookOut(1'b1);
            lo = (i == 0) ? 16'hffff : 16'($urandom());
            wr(32'h4, lo);
            lookOut(1'b0);
            sp = {(i == 0) ? 16'hffff : 16'($urandom()), lo};
            wr(32'h8, sp[31:16]);
            lookOut(1'b1);
            rdchk("status", 32'h0, expStat(1'b0));
            rdchk("word one", 32'h4, expWord(1'b0, 1'b0));
            rdchk("word two", 32'h8, expWord(1'b0, 1'b1));
            rdchk("setpoint low", 32'h14, {16'h0, sp[15:0]});
            rdchk("setpoint high", 32'h18, {16'h0, sp[31:16]});
            rdchk("ctrl readback", 32'h10, {16'h0, ctl});
        end
        $display("test position done");
        // Switch to extended status and back; old content until acknowledged
        for (int k = 1; k >= 0; k--)
        begin
            ext = (k == 1);
            ctl[11] = ext;
            wr(32'h0, ctl);
            rdchk("ack pending", 32'h0, expStat(~ext));
            rdchk("old word one", 32'h4, expWord(~ext, 1'b0));
            repeat (ST + 2) @(posedge sys_clk);
            rdchk("ack", 32'h0, expStat(ext));
            rdchk("new word one", 32'h4, expWord(ext, 1'b0));
            rdchk("new word two", 32'h8, expWord(ext, 1'b1));
        end
        $display("test switch done");
        // Holes, unaligned and narrow accesses are ignored and read zero
        wr(32'hc, 16'hffff);
        wr(32'h2, 16'hffff);
        xfer(1'b1, 32'h0, 32'hffff_ffff, 3'h0);
        lookOut(1'b0);
        rdchk("hole", 32'hc, 32'h0);
        rdchk("beyond", 32'h20, 32'h0);
        xfer(1'b0, 32'h0, 32'h0, 3'h1);
        check("halfword read", rd, 48'h0);
        $display("test refused done");
        finish_test();
    end
endmodule
